// *** rtl/sensor_out_pkg.sv ***
// Purpose: shared constants and types of the sensor output config block
// Assumes: 16-bit registers at 9-bit word addresses on the serial port
// Notes:   all field positions and reset values live here
package sensor_out_pkg;
    localparam int ADDR_W = 9;
    localparam int REG_W  = 16;
    localparam int PIX_W  = 10;
    localparam int WIN_W  = 4;
    localparam int ACC_W  = 17;
    localparam int CNT_W  = 8;
    localparam int OFS_W  = 11;

    // serial frame: address, write flag, then data, msb first
    localparam logic [4:0] SPI_CMD_BITS   = 5'h0a;
    localparam logic [4:0] SPI_FRAME_BITS = 5'h1a;
    localparam logic [4:0] SPI_CNT_MAX    = 5'h1f;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_LANE_PWR  = 9'h070;
    localparam logic [ADDR_W-1:0] OFS_DARK_CFG  = 9'h080;
    localparam logic [ADDR_W-1:0] OFS_GEN_CFG   = 9'h081;
    localparam logic [ADDR_W-1:0] OFS_ALIGN     = 9'h082;
    localparam logic [ADDR_W-1:0] OFS_FRAME_MRK = 9'h083;

    // reset values
    localparam logic [REG_W-1:0] RST_LANE_PWR  = 16'h0000;
    localparam logic [REG_W-1:0] RST_DARK_CFG  = 16'h4008;
    localparam logic [REG_W-1:0] RST_GEN_CFG   = 16'hc001;
    localparam logic [REG_W-1:0] RST_ALIGN     = 16'h03a6;
    localparam logic [REG_W-1:0] RST_FRAME_MRK = 16'h002a;
    localparam logic [REG_W-1:0] RD_UNMAPPED   = 16'h0000;

    // field positions
    localparam int CLK_PWR_B  = 0;
    localparam int SYNC_PWR_B = 1;
    localparam int DATA_PWR_B = 2;
    localparam int TGT_LSB    = 0;
    localparam int TGT_W      = 8;
    localparam int SAMP_LSB   = 8;
    localparam int SAMP_W     = 3;
    localparam int SEED_B     = 15;
    localparam int AUTO_B     = 0;
    localparam int MOFS_LSB   = 1;
    localparam int MOFS_W     = 9;
    localparam int SUB_B      = 10;
    localparam int NARROW_B   = 13;
    localparam int FSYNC_W    = 7;
    localparam int NARROW_LSB = 2;

    // fixed top bits of the frame marker word: start, end
    localparam logic [2:0] MARK_START = 3'h6;
    localparam logic [2:0] MARK_END   = 3'h5;

    localparam int WID_SHIFT = 4;
    localparam logic [PIX_W-1:0] CRC_POLY = 10'h233;

    typedef struct packed {
        logic             valid;
        logic             black;
        logic             frame_start;
        logic             frame_end;
        logic [WIN_W-1:0] win_id;
        logic [PIX_W-1:0] data;
    } pix_in_t;

    typedef struct packed {
        logic [PIX_W-1:0] data_word;
        logic [PIX_W-1:0] sync_word;
        logic [WIN_W-1:0] win_id;
    } lane_out_t;

    typedef enum logic [1:0] {
        SPI_IDLE = 2'b01,
        SPI_XFER = 2'b10
    } spi_state_t;

    typedef enum logic [1:0] {
        CAL_COLLECT = 2'b01,
        CAL_HOLD    = 2'b10
    } cal_state_t;
endpackage

// *** rtl/sensor_output_data_config.sv ***
// Purpose: output config, black calibration, lane words
// Assumes: pixel stream on clk; serial pins async
// Notes:   one pipeline stage from pixel input to lane words
// How it works
// (R1) clock lane powered only when its bit set
// (R2) sync lane powered only when its bit set
// (R3) data lanes powered only when their bit set
// (R4) target dark level field, reset eight
// (R5) average two-to-the-field black samples
// (R6) checksum seeded all zeros or all ones
// (R7) automatic calibration on when bit set
// (R8) manual offset used when automatic is off
// (R9) manual offset added or subtracted by bit
// (R10) narrow word mode, window id delayed four
// (R11) idle data lanes send alignment word
// (R12) receiver aligns words using idle word
// (R13) frame word: fixed top three, seven programmable
// (R14) auto offset brings black average to target
`timescale 1ns/100ps
module sensor_output_data_config
    import sensor_out_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        sclk_pin,
    input  wire logic        ss_n_pin,
    input  wire logic        mosi_pin,
    output logic             miso,
    input  wire pix_in_t     pix_in,
    output lane_out_t        lanes,
    output logic             clk_lane_pwr,
    output logic             sync_lane_pwr,
    output logic             data_lane_pwr,
    output logic [PIX_W-1:0] crc_out
);
    logic              rst_s1, rst_n;
    logic [ADDR_W-1:0] cfg_addr;
    logic [REG_W-1:0]  cfg_wdata, cfg_rdata;
    logic              cfg_wr;

    logic [REG_W-1:0] pwr_reg, pwr_next;
    logic [REG_W-1:0] dark_reg, dark_next;
    logic [REG_W-1:0] gen_reg, gen_next;
    logic [REG_W-1:0] align_reg, align_next;
    logic [REG_W-1:0] mark_reg, mark_next;

    cal_state_t        cal_reg, cal_next;
    logic [ACC_W-1:0]  acc_reg, acc_next;
    logic [CNT_W-1:0]  cnt_reg, cnt_next;
    logic [OFS_W-1:0]  ofs_reg, ofs_next;

    lane_out_t         lanes_reg, lanes_next;
    logic [WIN_W-1:0]  dly_reg [WID_SHIFT];
    logic [WIN_W-1:0]  dly_next [WID_SHIFT];
    logic [PIX_W-1:0]  crc_reg, crc_next;
    logic [2:0]        pwr_o_reg, pwr_o_next;

    logic [TGT_W-1:0]  target;
    logic [SAMP_W-1:0] samp_exp;
    logic [MOFS_W-1:0] man_ofs;
    logic              auto_en, narrow, active;
    logic [OFS_W-1:0]  eff_ofs;
    logic [PIX_W-1:0]  corr;
    logic [ACC_W-1:0]  acc_sum;
    logic [PIX_W-1:0]  avg;
    logic [CNT_W-1:0]  need;

    // add a signed offset and clamp to the pixel range
    function automatic logic [PIX_W-1:0] apply_ofs(
        input logic [PIX_W-1:0] d,
        input logic [OFS_W-1:0] o);
        logic [OFS_W:0] s;
        s = {2'b00, d} + {o[OFS_W-1], o};
        if (s[OFS_W])
            apply_ofs = '0;
        else if (s[PIX_W])
            apply_ofs = '1;
        else
            apply_ofs = s[PIX_W-1:0];
    endfunction

    // one pixel word folded into the checksum, msb first
    function automatic logic [PIX_W-1:0] crc_step(
        input logic [PIX_W-1:0] c,
        input logic [PIX_W-1:0] d);
        logic [PIX_W-1:0] r;
        r = c;
        for (int i = PIX_W - 1; i >= 0; i--)
        begin
            if (r[PIX_W-1] ^ d[i])
                r = {r[PIX_W-2:0], 1'b0} ^ CRC_POLY;
            else
                r = {r[PIX_W-2:0], 1'b0};
        end
        crc_step = r;
    endfunction

    // register read decode; unmapped offsets read as zero
    function automatic logic [REG_W-1:0] reg_read(
        input logic [ADDR_W-1:0] a);
        case (a)
            OFS_LANE_PWR:  reg_read = pwr_reg;
            OFS_DARK_CFG:  reg_read = dark_reg;
            OFS_GEN_CFG:   reg_read = gen_reg;
            OFS_ALIGN:     reg_read = align_reg;
            OFS_FRAME_MRK: reg_read = mark_reg;
            default:       reg_read = RD_UNMAPPED;
        endcase
    endfunction

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    spi_cfg_port u_port (
        .clk      (clk),
        .rst_n    (rst_n),
        .sclk_pin (sclk_pin),
        .ss_n_pin (ss_n_pin),
        .mosi_pin (mosi_pin),
        .rd_data  (cfg_rdata),
        .miso     (miso),
        .addr     (cfg_addr),
        .wr_data  (cfg_wdata),
        .wr_stb   (cfg_wr)
    );

    assign cfg_rdata = reg_read(cfg_addr);

    // register writes; reserved bits are kept as written
    always_comb
    begin
        pwr_next   = pwr_reg;
        dark_next  = dark_reg;
        gen_next   = gen_reg;
        align_next = align_reg;
        mark_next  = mark_reg;
        if (cfg_wr)
        begin
            case (cfg_addr)
                OFS_LANE_PWR:  pwr_next   = cfg_wdata;
                OFS_DARK_CFG:  dark_next  = cfg_wdata;
                OFS_GEN_CFG:   gen_next   = cfg_wdata;
                OFS_ALIGN:     align_next = cfg_wdata;
                OFS_FRAME_MRK: mark_next  = cfg_wdata;
                default:       pwr_next   = pwr_reg;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwr_reg   <= RST_LANE_PWR;
            dark_reg  <= RST_DARK_CFG; // R4
            gen_reg   <= RST_GEN_CFG;
            align_reg <= RST_ALIGN;
            mark_reg  <= RST_FRAME_MRK;
        end
        else
        begin
            pwr_reg   <= pwr_next;
            dark_reg  <= dark_next;
            gen_reg   <= gen_next;
            align_reg <= align_next;
            mark_reg  <= mark_next;
        end
    end

    // field views
    assign target   = dark_reg[TGT_LSB +: TGT_W]; // R4
    assign samp_exp = dark_reg[SAMP_LSB +: SAMP_W];
    assign man_ofs  = gen_reg[MOFS_LSB +: MOFS_W];
    assign auto_en  = gen_reg[AUTO_B];
    assign narrow   = gen_reg[NARROW_B];
    assign active   = pix_in.valid & ~pix_in.black;
    assign need     = {{(CNT_W-1){1'b0}}, 1'b1} << samp_exp; // R5
    assign acc_sum  = acc_reg + {{(ACC_W-PIX_W){1'b0}}, pix_in.data};
    assign avg      = PIX_W'(acc_sum >> samp_exp); // R5

    // offset choice: computed when automatic, else signed manual value
    always_comb
    begin
        if (auto_en) // R7
            eff_ofs = ofs_reg; // R14
        else if (gen_reg[SUB_B]) // R9
            eff_ofs = OFS_W'(-{2'b00, man_ofs}); // R8
        else
            eff_ofs = {2'b00, man_ofs}; // R8
    end

    assign corr = apply_ofs(pix_in.data, eff_ofs);

    // black calibration: gather samples each frame, then hold offset;
    // a frame with too few black samples keeps the previous offset
    always_comb
    begin
        cal_next = cal_reg;
        acc_next = acc_reg;
        cnt_next = cnt_reg;
        ofs_next = ofs_reg;
        if (pix_in.frame_start)
        begin
            cal_next = CAL_COLLECT;
            acc_next = '0;
            cnt_next = '0;
        end
        else
        begin
            case (cal_reg)
                CAL_COLLECT:
                    if (pix_in.valid && pix_in.black && auto_en) // R7
                    begin
                        acc_next = acc_sum;
                        cnt_next = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
                        if (cnt_next == need) // R5
                        begin
                            cal_next = CAL_HOLD;
                            ofs_next = {3'b000, target}
                                     - {1'b0, avg}; // R14
                        end
                    end
                CAL_HOLD:
                    cal_next = CAL_HOLD;
                default:
                    cal_next = CAL_COLLECT;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cal_reg <= CAL_COLLECT;
            acc_reg <= '0;
            cnt_reg <= '0;
            ofs_reg <= '0;
        end
        else
        begin
            cal_reg <= cal_next;
            acc_reg <= acc_next;
            cnt_reg <= cnt_next;
            ofs_reg <= ofs_next;
        end
    end

    // lane words, window id delay, checksum and power enables
    always_comb
    begin
        lanes_next = lanes_reg;
        for (int i = WID_SHIFT - 1; i > 0; i--)
            dly_next[i] = dly_reg[i-1];
        dly_next[0] = pix_in.win_id;
        crc_next    = crc_reg;
        pwr_o_next  = {pwr_reg[DATA_PWR_B], // R3
                       pwr_reg[SYNC_PWR_B], // R2
                       pwr_reg[CLK_PWR_B]}; // R1
        // a powered-down lane sends all zeros
        if (!pwr_reg[DATA_PWR_B])
            lanes_next.data_word = '0; // R3
        else if (active && narrow)
            lanes_next.data_word = {2'b00, corr[PIX_W-1:NARROW_LSB]}; // R10
        else if (active)
            lanes_next.data_word = corr;
        else
            lanes_next.data_word = align_reg[PIX_W-1:0]; // R11
        if (!pwr_reg[SYNC_PWR_B])
            lanes_next.sync_word = '0; // R2
        else if (pix_in.frame_start)
            lanes_next.sync_word = {MARK_START,
                                    mark_reg[FSYNC_W-1:0]}; // R13
        else if (pix_in.frame_end)
            lanes_next.sync_word = {MARK_END,
                                    mark_reg[FSYNC_W-1:0]}; // R13
        else
            lanes_next.sync_word = align_reg[PIX_W-1:0];
        // narrow mode moves window id four cycles behind the data
        lanes_next.win_id = narrow ? dly_reg[WID_SHIFT-1]
                                   : pix_in.win_id; // R10
        if (pix_in.frame_start)
            crc_next = dark_reg[SEED_B] ? '1 : '0; // R6
        else if (active)
            crc_next = crc_step(crc_reg, lanes_next.data_word);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lanes_reg <= '0;
            for (int i = 0; i < WID_SHIFT; i++)
                dly_reg[i] <= '0;
            crc_reg   <= '0;
            pwr_o_reg <= 3'h0;
        end
        else
        begin
            lanes_reg <= lanes_next;
            for (int i = 0; i < WID_SHIFT; i++)
                dly_reg[i] <= dly_next[i];
            crc_reg   <= crc_next;
            pwr_o_reg <= pwr_o_next;
        end
    end

    assign lanes         = lanes_reg;
    assign crc_out       = crc_reg;
    assign clk_lane_pwr  = pwr_o_reg[0];
    assign sync_lane_pwr = pwr_o_reg[1];
    assign data_lane_pwr = pwr_o_reg[2];
endmodule

// *** rtl/spi_cfg_port.sv ***
// Purpose: serial configuration port slave, oversampled by clk
// Assumes: sclk idles low, sample on rise, shift on fall
// Notes:   pins pass two flops before any logic reads them
`timescale 1ns/100ps
module spi_cfg_port
    import sensor_out_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              sclk_pin,
    input  wire logic              ss_n_pin,
    input  wire logic              mosi_pin,
    input  wire logic [REG_W-1:0]  rd_data,
    output logic                   miso,
    output logic [ADDR_W-1:0]      addr,
    output logic [REG_W-1:0]       wr_data,
    output logic                   wr_stb
);
    logic [2:0]                sclk_sy;
    logic [1:0]                ss_sy;
    logic [1:0]                mosi_sy;
    spi_state_t                state_reg, state_next;
    logic [4:0]                cnt_reg, cnt_next;
    logic [SPI_FRAME_BITS-1:0] sh_reg, sh_next;
    logic [REG_W-1:0]          tx_reg, tx_next;
    logic [ADDR_W-1:0]         addr_reg, addr_next;
    logic [REG_W-1:0]          wd_reg, wd_next;
    logic                      wr_reg, wr_next;
    logic                      rw_reg, rw_next;
    logic                      rise, fall, ss_n, mosi;

    // synchronisers; edges use only the second and third stages
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_sy <= 3'h0;
            ss_sy   <= 2'h3;
            mosi_sy <= 2'h0;
        end
        else
        begin
            sclk_sy <= {sclk_sy[1:0], sclk_pin};
            ss_sy   <= {ss_sy[0], ss_n_pin};
            mosi_sy <= {mosi_sy[0], mosi_pin};
        end
    end

    assign rise = sclk_sy[1] & ~sclk_sy[2];
    assign fall = ~sclk_sy[1] & sclk_sy[2];
    assign ss_n = ss_sy[1];
    assign mosi = mosi_sy[1];

    // frame decode; read data is loaded on the falling edge after the
    // write flag so the master sees its msb at the next rising edge
    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        sh_next    = sh_reg;
        tx_next    = tx_reg;
        addr_next  = addr_reg;
        wd_next    = wd_reg;
        wr_next    = 1'b0;
        rw_next    = rw_reg;
        case (state_reg)
            SPI_IDLE:
                if (!ss_n)
                begin
                    state_next = SPI_XFER;
                    cnt_next   = 5'h00;
                    tx_next    = '0;
                end
            SPI_XFER:
                if (ss_n)
                    state_next = SPI_IDLE;
                else
                begin
                    if (rise && cnt_reg != SPI_CNT_MAX)
                    begin
                        sh_next  = {sh_reg[SPI_FRAME_BITS-2:0], mosi};
                        cnt_next = cnt_reg + 5'h01;
                        if (cnt_reg == SPI_CMD_BITS - 5'h01)
                        begin
                            addr_next = sh_reg[ADDR_W-1:0];
                            rw_next   = mosi;
                        end
                        if (cnt_reg == SPI_FRAME_BITS - 5'h01 && rw_reg)
                        begin
                            wr_next = 1'b1;
                            wd_next = {sh_reg[REG_W-2:0], mosi};
                        end
                    end
                    if (fall && cnt_reg == SPI_CMD_BITS)
                        tx_next = rd_data;
                    else if (fall && cnt_reg > SPI_CMD_BITS)
                        tx_next = {tx_reg[REG_W-2:0], 1'b0};
                end
            default:
                state_next = SPI_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= SPI_IDLE;
            cnt_reg   <= 5'h00;
            sh_reg    <= '0;
            tx_reg    <= '0;
            addr_reg  <= '0;
            wd_reg    <= '0;
            wr_reg    <= 1'b0;
            rw_reg    <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            sh_reg    <= sh_next;
            tx_reg    <= tx_next;
            addr_reg  <= addr_next;
            wd_reg    <= wd_next;
            wr_reg    <= wr_next;
            rw_reg    <= rw_next;
        end
    end

    assign miso    = tx_reg[REG_W-1];
    assign addr    = addr_reg;
    assign wr_data = wd_reg;
    assign wr_stb  = wr_reg;
endmodule

// *** verif/lane_receiver.sv ***
// Purpose: receiver model, word-aligns on the idle word
// Assumes: one deserialized word per clk
// Notes:   pixels counted after four idle words
`timescale 1ns/100ps
module lane_receiver
    import sensor_out_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire lane_out_t        lanes,
    input  wire logic [PIX_W-1:0] align_word,
    output logic                  locked,
    output logic [7:0]            n_pix
);
    logic [2:0] hits_reg;
    logic [2:0] hits_next;
    logic [7:0] n_pix_reg;
    logic [7:0] n_pix_next;

    // a stray word before lock restarts the search
    always_comb
    begin
        hits_next  = hits_reg;
        n_pix_next = n_pix_reg;
        if (lanes.data_word == align_word)
            hits_next = (hits_reg == 3'h4) ? hits_reg : hits_reg + 3'h1;
        else if (hits_reg != 3'h4)
            hits_next = 3'h0;
        else
            n_pix_next = n_pix_reg + 8'h01;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hits_reg  <= 3'h0;
            n_pix_reg <= 8'h00;
        end
        else
        begin
            hits_reg  <= hits_next;
            n_pix_reg <= n_pix_next;
        end
    end

    assign locked = (hits_reg == 3'h4);
    assign n_pix  = n_pix_reg;
endmodule

// *** verif/sensor_cfg_checker.sv ***
// Purpose: port-level checks of the output config block
// Assumes: frame_start and frame_end never together
// Notes:   bind at the foot
`timescale 1ns/100ps
module sensor_cfg_checker
    import sensor_out_pkg::*;
(
    input wire logic             clk,
    input wire logic             resetn,
    input wire logic             sclk_pin,
    input wire logic             ss_n_pin,
    input wire logic             mosi_pin,
    input wire logic             miso,
    input wire pix_in_t          pix_in,
    input wire lane_out_t        lanes,
    input wire logic             clk_lane_pwr,
    input wire logic             sync_lane_pwr,
    input wire logic             data_lane_pwr,
    input wire logic [PIX_W-1:0] crc_out
);
    logic [3:0] quiet_reg;
    logic [3:0] quiet_next;

    // clocks since select rose; writes land well before 15
    always_comb
    begin
        quiet_next = quiet_reg;
        if (!ss_n_pin)
            quiet_next = 4'h0;
        else if (quiet_reg != 4'hf)
            quiet_next = quiet_reg + 4'h1;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            quiet_reg <= 4'h0;
        else
            quiet_reg <= quiet_next;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    a_data_lane_off: assert property (
        (!data_lane_pwr)[*3] |-> lanes.data_word == 10'h000)
        else $error("data word with lanes off");
    a_sync_lane_off: assert property (
        (!sync_lane_pwr)[*3] |-> lanes.sync_word == 10'h000)
        else $error("sync word with lane off");
    a_start_mark_top: assert property (
        $past(pix_in.frame_start) && sync_lane_pwr && $past(sync_lane_pwr)
        |-> lanes.sync_word[9:7] == MARK_START)
        else $error("start marker wrong");
    a_end_mark_top: assert property (
        $past(pix_in.frame_end) && !$past(pix_in.frame_start)
        && sync_lane_pwr && $past(sync_lane_pwr)
        |-> lanes.sync_word[9:7] == MARK_END)
        else $error("end marker wrong");
    a_crc_seed_val: assert property (
        $past(pix_in.frame_start)
        |-> crc_out == 10'h000 || crc_out == 10'h3ff)
        else $error("bad checksum seed");
    a_crc_idle_hold: assert property (
        !$past(pix_in.valid) && !$past(pix_in.frame_start)
        |-> $stable(crc_out))
        else $error("checksum moved idle");
    a_idle_word_hold: assert property (
        quiet_reg == 4'hf && !$past(pix_in.valid) && !$past(pix_in.valid, 2)
        |-> $stable(lanes.data_word))
        else $error("idle word changed");
    a_lane_pwr_hold: assert property (
        quiet_reg == 4'hf
        |-> $stable({clk_lane_pwr, sync_lane_pwr, data_lane_pwr}))
        else $error("lane power moved idle");
    a_reset_quiet: assert property (
        $rose(resetn) |-> (!clk_lane_pwr && !sync_lane_pwr
        && !data_lane_pwr && lanes == '0)[*2])
        else $error("outputs live after reset");
endmodule

bind sensor_output_data_config sensor_cfg_checker u_chk (
    .clk(clk), .resetn(resetn), .sclk_pin(sclk_pin),
    .ss_n_pin(ss_n_pin), .mosi_pin(mosi_pin), .miso(miso),
    .pix_in(pix_in), .lanes(lanes), .clk_lane_pwr(clk_lane_pwr),
    .sync_lane_pwr(sync_lane_pwr), .data_lane_pwr(data_lane_pwr),
    .crc_out(crc_out));

// *** verif/tb_sensor_output_data_config.sv ***
// Purpose: register and lane word tests
// Assumes: frame of 9 address, flag, 16 data bits
// Notes:   inputs change on falling clk; serial clock 200 ns
`timescale 1ns/100ps
module tb_sensor_output_data_config;
    import sensor_out_pkg::*;
    logic             clk, resetn, sclk_pin, ss_n_pin, mosi_pin, miso;
    logic             clk_lane_pwr, sync_lane_pwr, data_lane_pwr, locked;
    pix_in_t          pix_in;
    lane_out_t        lanes;
    logic [PIX_W-1:0] crc_out, align_word;
    logic [15:0]      rd;
    int               miscompares, n_compared;
    logic [8:0]  offs [6] = '{9'h070, 9'h080, 9'h081, 9'h082, 9'h083, 9'h084};
    logic [15:0] rsts [6] = '{16'h0, 16'h4008, 16'hc001, 16'h03a6, 16'h2a, 16'h0};
    logic [15:0] cfgs [4] = '{16'hc00a, 16'hc40a, 16'hc40a, 16'hc00a};
    logic [9:0]  pins [4] = '{10'd100, 10'd100, 10'd2, 10'd1020};
    logic [9:0]  pexp [4] = '{10'd105, 10'd95, 10'd0, 10'd1023};

    sensor_output_data_config u_dut (.clk(clk), .resetn(resetn),
        .sclk_pin(sclk_pin), .ss_n_pin(ss_n_pin), .mosi_pin(mosi_pin),
        .miso(miso), .pix_in(pix_in), .lanes(lanes),
        .clk_lane_pwr(clk_lane_pwr), .sync_lane_pwr(sync_lane_pwr),
        .data_lane_pwr(data_lane_pwr), .crc_out(crc_out));
    lane_receiver u_rx (.clk(clk), .rst_n(resetn), .lanes(lanes),
        .align_word(align_word), .locked(locked), .n_pix());

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    task automatic complete_run();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // one frame; miso read at each data rising edge
    task automatic xfer(input logic [8:0] a, input logic w,
                        input logic [15:0] d);
        logic [25:0] f;
        f = {a, w, d};
        ss_n_pin = 1'b0;
        for (int i = 25; i >= 0; i--)
        begin
            mosi_pin = f[i];
            wait_clk(4);
            sclk_pin = 1'b1;
            if (i < 16)
                rd[i] = miso;
            wait_clk(4);
            sclk_pin = 1'b0;
        end
        wait_clk(4);
        ss_n_pin = 1'b1;
        wait_clk(8);
    endtask

    task automatic reg_rd(input logic [8:0] a, input logic [15:0] exp);
        xfer(a, 1'b0, 16'h0000);
        chk(rd, exp);
    endtask

    // flags are valid, black, start, end; held until the next call
    task automatic pix(input logic [3:0] f, input logic [3:0] w,
                       input logic [9:0] d);
        pix_in = {f, w, d};
        wait_clk(1);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        complete_run();
    end

    initial
    begin
        resetn = 1'b0;
        sclk_pin = 1'b0;
        ss_n_pin = 1'b1;
        mosi_pin = 1'b0;
        pix_in = '0;
        align_word = 10'h3a6;
        miscompares = 0;
        n_compared = 0;
        wait_clk(5);
        resetn = 1'b1;
        wait_clk(4);
        // reset values, then an unmapped offset reads zero
        foreach (offs[i])
            reg_rd(offs[i], rsts[i]);
        chk({13'h0, data_lane_pwr, sync_lane_pwr, clk_lane_pwr}, 16'h0);
        for (int i = 0; i < 3; i++)
        begin
            xfer(9'h070, 1'b1, 16'h0001 << i);
            chk({13'h0, data_lane_pwr, sync_lane_pwr, clk_lane_pwr},
                16'h0001 << i);
        end
        xfer(9'h070, 1'b1, 16'h0007);
        reg_rd(9'h070, 16'h0007);
        chk({6'h0, lanes.data_word}, 16'h03a6);
        chk({15'h0, locked}, 16'h0001);
        xfer(9'h082, 1'b1, 16'h0155);
        align_word = 10'h155;
        chk({6'h0, lanes.data_word}, 16'h0155);
        // marker top bits written as ones must not show
        xfer(9'h083, 1'b1, 16'h03d5);
        pix(4'h2, 4'h0, 10'h0);
        chk({6'h0, lanes.sync_word}, 16'h0355);
        chk({6'h0, crc_out}, 16'h0000);
        pix(4'h1, 4'h0, 10'h0);
        chk({6'h0, lanes.sync_word}, 16'h02d5);
        pix(4'h0, 4'h0, 10'h0);
        xfer(9'h080, 1'b1, 16'hc008);
        pix(4'h2, 4'h0, 10'h0);
        chk({6'h0, crc_out}, 16'h03ff);
        // manual offset added, subtracted and clamped at both ends
        foreach (cfgs[i])
        begin
            xfer(9'h081, 1'b1, cfgs[i]);
            pix(4'h8, 4'h0, pins[i]);
            chk({6'h0, lanes.data_word}, {6'h0, pexp[i]});
            pix(4'h0, 4'h0, 10'h0);
        end
        // four black samples 10..16 average 13, target 0x20: offset 19
        xfer(9'h080, 1'b1, 16'h0220);
        xfer(9'h081, 1'b1, 16'hc001);
        pix(4'h2, 4'h0, 10'h0);
        for (int i = 0; i < 4; i++)
            pix(4'hc, 4'h0, 10'(10 + 2 * i));
        chk({6'h0, lanes.data_word}, 16'h0155);
        pix(4'h0, 4'h0, 10'h0);
        pix(4'h8, 4'h0, 10'd100);
        chk({6'h0, lanes.data_word}, 16'd119);
        // wide then narrow words; window id lags one or five clocks
        for (int m = 0; m < 2; m++)
        begin
            xfer(9'h081, 1'b1, m ? 16'he000 : 16'hc000);
            for (int i = 0; i < 12; i++)
            begin
                if (i >= 5)
                    chk({12'h0, lanes.win_id},
                        {12'h0, 4'(i - (m ? 5 : 1))});
                pix(4'h8, 4'(i), 10'h3fc);
            end
            chk({6'h0, lanes.data_word}, m ? 16'h00ff : 16'h03fc);
            pix(4'h0, 4'h0, 10'h0);
        end
        // mid-run reset restores the lane power and alignment registers
        resetn = 1'b0;
        wait_clk(3);
        resetn = 1'b1;
        wait_clk(4);
        reg_rd(9'h070, 16'h0000);
        reg_rd(9'h082, 16'h03a6);
        complete_run();
    end
endmodule
